// >>> core/aco_cfg.svh
// constants for the converter output port
`ifndef ACO_CFG_SVH
`define ACO_CFG_SVH
`define ACO_W 10
`define ACO_SIGN 10'h200
`define ACO_ADDR_W 4
`define ACO_OFS_CTRL 4'h0
`define ACO_OFS_STAT 4'h4
`define ACO_OFS_WORD 4'h8
`define ACO_OFS_CNT 4'hC
`define ACO_CTRL_PDS 0
`define ACO_CTRL_OEN 1
`define ACO_CTRL_OMODE 3:2
`define ACO_CTRL_FMT 5:4
`define ACO_CTRL_HOLD 6
`define ACO_CTRL_RST 7'h00
`define ACO_RESP_OK 2'h0
`define ACO_RESP_ERR 2'h2
`define ACO_FIFO_D 2
`endif

// >>> core/aco_pkg.sv
// types shared by the converter output port
`default_nettype none
package aco_pkg;
  typedef enum logic [1:0] {
    OM_FULL = 2'h0,
    OM_SIMUL = 2'h1,
    OM_INTER = 2'h2,
    OM_LVDS = 2'h3
  } aco_omode_t;
  typedef enum logic [2:0] {
    PW_RUN = 3'h1,
    PW_NAP = 3'h2,
    PW_SLEEP = 3'h4
  } aco_pwr_t;
  typedef struct packed {
    logic ovr;
    logic [9:0] code;
  } aco_word_t;
endpackage : aco_pkg
`default_nettype wire

// >>> core/aco_output_port.sv
// converter output port: straps over axi4-lite, encode sampling, output buses
`include "aco_cfg.svh"
`default_nettype none
// Behaviour
// - a conversion starts on the rising edge of the true encode input
// - power-down low, enable low: convert and drive the outputs that the output mode uses
// - power-down low, enable high: convert, outputs high impedance
// - power-down high, enable low: nap, outputs high impedance
// - power-down high, enable high: sleep, outputs high impedance
// - output-mode setting picks full-rate, demux simultaneous, demux interleaved, lvds
// - format setting picks binary or two's complement and stabiliser
// - two's complement: just above zero all zeros, just below all ones
// - primary bus is 10 bits, bit 9 most significant
// - second bus is 10 bits, high impedance in full-rate mode
// - primary range flag high for overflowed or underflowed word
// - second range flag likewise, high impedance in full-rate mode
// - second valid clock stays driven in full-rate mode
module aco_output_port
  import aco_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic encode_clk_p,
  input wire logic encode_clk_n,
  input wire logic [9:0] convCode,
  input wire logic convOvr,
  output logic convReady,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output aco_word_t primary_bus_word,
  output logic primaryOeN,
  output aco_word_t second_bus_word,
  output logic secondOeN,
  output logic primary_valid_clk,
  output logic second_valid_clk,
  output logic secondClkOeN,
  output logic diff_valid_clk_p,
  output logic diff_valid_clk_n,
  output logic diffClkOeN
);

  // ==========================================
  // register slave
  logic [6:0] ctrl_q;
  logic [15:0] convCnt_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wrTake;
  logic rdTake;
  logic ctrlPds;
  logic ctrlOeN;
  logic ctrlHold;
  aco_omode_t oMode;
  logic [1:0] fmtSel;
  logic fmtTwos;
  logic stabOn;
  aco_pwr_t pwr_q;
  logic running;
  logic fifoFull;
  aco_word_t lastWord_q;

  // address and data are taken together, one write outstanding
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rdTake = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wrTake;
  assign s_axi_wready = wrTake;
  assign s_axi_arready = rdTake;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  assign ctrlPds = ctrl_q[`ACO_CTRL_PDS];
  assign ctrlOeN = ctrl_q[`ACO_CTRL_OEN];
  assign ctrlHold = ctrl_q[`ACO_CTRL_HOLD];
  assign oMode = aco_omode_t'(ctrl_q[`ACO_CTRL_OMODE]);
  assign fmtSel = ctrl_q[`ACO_CTRL_FMT];
  assign fmtTwos = fmtSel[1];
  assign stabOn = fmtSel[1] ^ fmtSel[0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= `ACO_CTRL_RST;
    end else if (wrTake && s_axi_awaddr == `ACO_OFS_CTRL && s_axi_wstrb[0]) begin
      ctrl_q <= s_axi_wdata[6:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ACO_RESP_OK;
    end else if (wrTake) begin
      bvalid_q <= 1'b1;
      // only the control word is writable
      bresp_q <= (s_axi_awaddr == `ACO_OFS_CTRL) ? `ACO_RESP_OK : `ACO_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rresp_q <= `ACO_RESP_OK;
      rdata_q <= 32'h0;
    end else if (rdTake) begin
      rvalid_q <= 1'b1;
      rresp_q <= `ACO_RESP_OK;
      case (s_axi_araddr)
        `ACO_OFS_CTRL: rdata_q <= {25'h0, ctrl_q};
        `ACO_OFS_STAT: rdata_q <= {26'h0, fifoFull, stabOn, fmtTwos, pwr_q};
        `ACO_OFS_WORD: rdata_q <= {21'h0, lastWord_q};
        `ACO_OFS_CNT: rdata_q <= {16'h0, convCnt_q};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= `ACO_RESP_ERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================
  // power state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_q <= PW_RUN;
    end else begin
      case ({ctrlPds, ctrlOeN})
        2'b10: pwr_q <= PW_NAP;
        2'b11: pwr_q <= PW_SLEEP;
        default: pwr_q <= PW_RUN;
      endcase
    end
  end
  assign running = (pwr_q == PW_RUN);

  // ==========================================
  // encode clock sampling
  logic encPMeta_q;
  logic encPSync_q;
  logic encNMeta_q;
  logic encNSync_q;
  logic encLvl_q;
  logic encLvl;
  logic encRise;
  logic encFall;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      encPMeta_q <= 1'b0;
      encPSync_q <= 1'b0;
      encNMeta_q <= 1'b1;
      encNSync_q <= 1'b1;
      encLvl_q <= 1'b0;
    end else begin
      encPMeta_q <= encode_clk_p;
      encPSync_q <= encPMeta_q;
      encNMeta_q <= encode_clk_n;
      encNSync_q <= encNMeta_q;
      encLvl_q <= encLvl;
    end
  end
  // true leg rising is complement leg falling
  assign encLvl = encPSync_q & ~encNSync_q;
  assign encRise = encLvl & ~encLvl_q;
  assign encFall = ~encLvl & encLvl_q;

  // ==========================================
  // two-entry word buffer
  aco_word_t fifoMem_q [`ACO_FIFO_D];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] fifoCnt_q;
  logic push;
  logic pop;
  logic fifoValid;
  aco_word_t head;
  aco_word_t fmtWord;

  assign fifoFull = (fifoCnt_q == 2'(`ACO_FIFO_D));
  assign convReady = ~fifoFull;
  assign fifoValid = (fifoCnt_q != 2'h0);
  // one conversion per encode rising edge
  assign push = encRise & running & convReady;
  // hold stalls the drain so the buffer backs up into convReady
  assign pop = encRise & running & fifoValid & ~ctrlHold;
  assign head = fifoMem_q[rdPtr_q];

  always_ff @(posedge core_clk) begin
    if (push) begin
      fifoMem_q[wrPtr_q] <= '{ovr: convOvr, code: convCode};
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      fifoCnt_q <= 2'h0;
      convCnt_q <= 16'h0;
    end else begin
      wrPtr_q <= wrPtr_q ^ push;
      rdPtr_q <= rdPtr_q ^ pop;
      fifoCnt_q <= fifoCnt_q + 2'(push) - 2'(pop);
      convCnt_q <= convCnt_q + 16'(push);
    end
  end

  // two's complement flips the msb of the offset code
  assign fmtWord = '{ovr: head.ovr, code: fmtTwos ? head.code ^ `ACO_SIGN : head.code};

  // ==========================================
  // output buses and valid clocks
  aco_word_t busA_q;
  aco_word_t busB_q;
  aco_word_t stage_q;
  logic clkA_q;
  logic clkB_q;
  logic bankSel_q;
  logic demux;

  assign demux = (oMode == OM_SIMUL) || (oMode == OM_INTER);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busA_q <= '0;
      busB_q <= '0;
      stage_q <= '0;
      clkA_q <= 1'b0;
      clkB_q <= 1'b0;
      bankSel_q <= 1'b0;
      lastWord_q <= '0;
    end else if (pop) begin
      lastWord_q <= fmtWord;
      bankSel_q <= demux ? ~bankSel_q : 1'b0;
      case (oMode)
        // alternate words go to a then b
        OM_INTER: begin
          if (!bankSel_q) begin
            busA_q <= fmtWord;
            clkA_q <= 1'b1;
            clkB_q <= 1'b0;
          end else begin
            busB_q <= fmtWord;
            clkB_q <= 1'b1;
            clkA_q <= 1'b0;
          end
        end
        // even word staged, both buses move on odd
        OM_SIMUL: begin
          if (!bankSel_q) begin
            stage_q <= fmtWord;
            clkA_q <= 1'b0;
            clkB_q <= 1'b1;
          end else begin
            busA_q <= stage_q;
            busB_q <= fmtWord;
            clkA_q <= 1'b1;
            clkB_q <= 1'b0;
          end
        end
        default: begin
          // full-rate and lvds use the primary bus
          busA_q <= fmtWord;
          clkA_q <= 1'b1;
          clkB_q <= 1'b1;
        end
      endcase
    end else if (encFall && !demux) begin
      // falling valid clock mid-word gives the capture edge
      clkA_q <= 1'b0;
      clkB_q <= 1'b0;
    end
  end

  assign primary_bus_word = busA_q;
  assign second_bus_word = busB_q;
  assign primary_valid_clk = clkA_q;
  assign second_valid_clk = clkB_q;
  assign diff_valid_clk_p = clkA_q;
  assign diff_valid_clk_n = ~clkA_q;

  // ==========================================
  // output enables, low while driving
  logic pOeN_q;
  logic sOeN_q;
  logic sClkOeN_q;
  logic dClkOeN_q;
  logic drive;

  // drive only when running with enable low
  assign drive = ~ctrlPds & ~ctrlOeN;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pOeN_q <= 1'b1;
      sOeN_q <= 1'b1;
      sClkOeN_q <= 1'b1;
      dClkOeN_q <= 1'b1;
    end else begin
      // other power states float the pins
      pOeN_q <= ~drive;
      // second bus floats in full-rate and lvds
      sOeN_q <= ~(drive & demux);
      // second clock driven in every cmos mode
      sClkOeN_q <= ~(drive & (oMode != OM_LVDS));
      dClkOeN_q <= ~(drive & (oMode == OM_LVDS));
    end
  end
  assign primaryOeN = pOeN_q;
  assign secondOeN = sOeN_q;
  assign secondClkOeN = sClkOeN_q;
  assign diffClkOeN = dClkOeN_q;

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // pin edge to push: two sync flops, then the edge register
  sequence s_encEdge;
    $rose(encode_clk_p) && $fell(encode_clk_n);
  endsequence
  property p_convStart;
    s_encEdge ##2 (running && convReady) |-> push;
  endproperty
  a_convStart: assert property (p_convStart) else $error("edge missed");
  property p_normal;
    (!ctrlPds && !ctrlOeN) |=> !primaryOeN && pwr_q == PW_RUN;
  endproperty
  a_normal: assert property (p_normal) else $error("not driving");
  property p_quiet;
    (!ctrlPds && ctrlOeN) |=> primaryOeN && secondOeN && pwr_q == PW_RUN;
  endproperty
  a_quiet: assert property (p_quiet) else $error("not floating");
  property p_nap;
    (ctrlPds && !ctrlOeN) |=> pwr_q == PW_NAP && primaryOeN && !push;
  endproperty
  a_nap: assert property (p_nap) else $error("nap wrong");
  property p_sleep;
    (ctrlPds && ctrlOeN) |=> pwr_q == PW_SLEEP && secondClkOeN && !push;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep wrong");
  property p_twos;
    (pop && oMode == OM_FULL && fmtTwos) |=>
      primary_bus_word.code == ($past(head.code) ^ `ACO_SIGN);
  endproperty
  a_twos: assert property (p_twos) else $error("bad coding");
  property p_floatB;
    (oMode == OM_FULL) |=> secondOeN;
  endproperty
  a_floatB: assert property (p_floatB) else $error("b bus driven");
  property p_clkB;
    (oMode == OM_FULL && drive) |=> !secondClkOeN;
  endproperty
  a_clkB: assert property (p_clkB) else $error("b clock floats");
  sequence s_interA;
    pop && oMode == OM_INTER && !bankSel_q;
  endsequence
  property p_alternate;
    s_interA |=> primary_valid_clk && !second_valid_clk && $stable(second_bus_word);
  endproperty
  a_alternate: assert property (p_alternate) else $error("bad alternation");
  property p_flag;
    (pop && oMode == OM_FULL) |=> primary_bus_word.ovr == $past(head.ovr);
  endproperty
  a_flag: assert property (p_flag) else $error("flag not with word");

endmodule : aco_output_port
`default_nettype wire

// >>> verification/aco_capture_model.sv
// capture logic that latches converter words on the data-valid clocks
`default_nettype none
module aco_capture_model
  import aco_pkg::*;
(
  input wire logic [1:0] mode,
  input wire aco_word_t primary_bus_word,
  input wire aco_word_t second_bus_word,
  input wire logic primaryOeN,
  input wire logic secondOeN,
  input wire logic primary_valid_clk,
  input wire logic second_valid_clk,
  input wire logic diff_valid_clk_n,
  input wire logic diffClkOeN
);
  aco_word_t capA[$];
  aco_word_t capB[$];
  // =====================================
  // capture edges
  // primary on falling
  always @(negedge primary_valid_clk) begin
    if (mode != OM_LVDS && !primaryOeN) capA.push_back(primary_bus_word);
  end
  always @(posedge diff_valid_clk_n) begin
    if (mode == OM_LVDS && !diffClkOeN) capA.push_back(primary_bus_word);
  end
  always @(negedge second_valid_clk) begin
    if (mode == OM_INTER && !secondOeN) capB.push_back(second_bus_word);
  end
  always @(posedge second_valid_clk) begin
    if (mode == OM_SIMUL && !secondOeN) capB.push_back(second_bus_word);
  end
endmodule : aco_capture_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the converter output port
`include "aco_cfg.svh"
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench
  import aco_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0, reset = 1'b1, encP = 1'b0, encPd = 1'b0, encRun = 1'b0;
  logic [9:0] convCode = 10'h1F0;
  logic convOvr = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd, c0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, convReady;
  logic [1:0] bresp, rresp, rsp, mode = 2'h0;
  aco_word_t wordA, wordB;
  logic oeA, oeB, clkA, clkB, clkOeB, dp, dn, oeD;
  int miscompares = 0, cmpCount = 0, cycles = 0;
  // =====================================
  // clocks and conversion source
  always #2 core_clk = ~core_clk;
  // encode stands low outside bursts; phase unrelated to core_clk
  initial begin
    #1.3;
    forever #16 encP = encRun ? ~encP : 1'b0;
  end
  always @(posedge core_clk) begin
    encPd <= encP;
    cycles <= cycles + 1;
    if (encP && !encPd) begin
      convCode <= convCode + 10'h1;
      convOvr <= ~convCode[0];
    end
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  aco_output_port aco_output_port_inst (.core_clk(core_clk), .reset(reset),
    .encode_clk_p(encP), .encode_clk_n(~encP), .convCode(convCode), .convOvr(convOvr),
    .convReady(convReady), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .primary_bus_word(wordA), .primaryOeN(oeA), .second_bus_word(wordB),
    .secondOeN(oeB), .primary_valid_clk(clkA), .second_valid_clk(clkB),
    .secondClkOeN(clkOeB), .diff_valid_clk_p(dp), .diff_valid_clk_n(dn), .diffClkOeN(oeD));
  aco_capture_model aco_capture_model_inst (.mode(mode), .primary_bus_word(wordA),
    .second_bus_word(wordB), .primaryOeN(oeA), .secondOeN(oeB), .primary_valid_clk(clkA),
    .second_valid_clk(clkB), .diff_valid_clk_n(dn), .diffClkOeN(oeD));
  // =====================================
  // bus tasks
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // valids raised by nonblocking assignment only show after the next edge
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge core_clk);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge core_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead
  task automatic setCtrl(input logic [6:0] v);
    axiWrite(`ACO_OFS_CTRL, {25'h0, v}, rsp);
    `CHK(rsp, `ACO_RESP_OK)
    repeat (3) @(posedge core_clk);
  endtask : setCtrl
  task automatic encode(input int n);
    encRun <= 1'b1;
    repeat (n) @(posedge core_clk);
    encRun <= 1'b0;
    repeat (24) @(posedge core_clk);
  endtask : encode
  // first capture may be a stale word from the previous mode
  task automatic chkSeq(input aco_word_t q[$], input logic [9:0] flip, input logic [9:0] st);
    `CHK(q.size() > 8, 1'b1)
    for (int i = 2; i < q.size(); i++) begin
      `CHK((q[i].code ^ flip) - (q[i-1].code ^ flip), st)
      `CHK(q[i].ovr, q[i].code[0])
    end
  endtask : chkSeq
  task automatic burst(input logic [9:0] flip, input logic [9:0] st, input logic both);
    aco_capture_model_inst.capA.delete();
    aco_capture_model_inst.capB.delete();
    encode(240);
    chkSeq(aco_capture_model_inst.capA, flip, st);
    if (both) chkSeq(aco_capture_model_inst.capB, flip, st);
  endtask : burst
  task automatic end_of_test();
    $display("mismatches %0d, compares %0d", miscompares, cmpCount);
    if (miscompares == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // =====================================
  // scenarios
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    axiRead(`ACO_OFS_CTRL, rd, rsp);
    `CHK(rd, 32'h0)
    axiRead(`ACO_OFS_STAT, rd, rsp);
    `CHK(rd[2:0], 3'h1)
    `CHK(oeA, 1'b0)
    setCtrl(7'h30);
    burst(10'h200, 10'h1, 1'b0);
    axiRead(`ACO_OFS_WORD, rd, rsp);
    `CHK(rd[9:0], (convCode - 10'h1) ^ `ACO_SIGN)
    `CHK(rd[10], ~convCode[0])
    for (int f = 0; f < 4; f++) begin
      setCtrl({1'b0, f[1:0], 4'h0});
      axiRead(`ACO_OFS_STAT, rd, rsp);
      `CHK(rd[4:3], {f == 1 || f == 2, f[1]})
    end
    for (int m = 0; m < 4; m++) begin
      mode <= m[1:0];
      setCtrl({3'h0, m[1:0], 2'h0});
      `CHK(oeB, !(m == 1 || m == 2))
      `CHK(clkOeB, m == 3)
      `CHK(oeD, m != 3)
      `CHK(oeA, 1'b0)
      burst(10'h0, (m == 1 || m == 2) ? 10'h2 : 10'h1, m == 1 || m == 2);
      `CHK(dn, ~dp)
    end
    mode <= OM_FULL;
    for (int p = 0; p < 4; p++) begin
      setCtrl({5'h0, p[1:0]});
      axiRead(`ACO_OFS_CNT, c0, rsp);
      encode(64);
      axiRead(`ACO_OFS_CNT, rd, rsp);
      `CHK(rd != c0, !p[0])
      `CHK(oeA, p != 0)
      axiRead(`ACO_OFS_STAT, rd, rsp);
      `CHK(rd[2:0], p[0] ? (p[1] ? 3'h4 : 3'h2) : 3'h1)
    end
    setCtrl(7'h40);
    encode(80);
    `CHK(convReady, 1'b0)
    axiRead(`ACO_OFS_STAT, rd, rsp);
    `CHK(rd[5], 1'b1)
    setCtrl(7'h00);
    encode(40);
    axiRead(`ACO_OFS_STAT, rd, rsp);
    `CHK(rd[5], 1'b0)
    axiWrite(`ACO_OFS_STAT, 32'h0, rsp);
    `CHK(rsp, `ACO_RESP_ERR)
    axiRead(4'h2, rd, rsp);
    `CHK(rsp, `ACO_RESP_ERR)
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
